/* File: logic/otg_pkg.sv */
// constants and carrier types for the channel-b overcurrent trip and gain trim block
// assumes a 16-bit register port with 8-bit word addresses and a 1-bit modulator stream
package otg_pkg;

    // register word addresses
    localparam logic [7:0]  ADDR_GAIN_TRIM   = 8'hC6;
    localparam logic [7:0]  ADDR_TRIP_CFG    = 8'hC7;
    localparam logic [7:0]  ADDR_TRIP_HIGH   = 8'hC8;
    localparam logic [7:0]  ADDR_TRIP_LOW    = 8'hC9;

    // reset values
    localparam logic [15:0] RST_GAIN_TRIM    = 16'h0000;
    localparam logic [15:0] RST_TRIP_CFG     = 16'h0000;
    localparam logic [15:0] RST_TRIP_HIGH    = 16'h7FFF;
    localparam logic [15:0] RST_TRIP_LOW     = 16'h8000;

    // limits that switch a comparison off
    localparam logic [15:0] HIGH_DISABLE     = 16'h7FFF;
    localparam logic [15:0] LOW_DISABLE      = 16'h8000;

    // config field positions
    localparam int          CFG_EN_BIT       = 15;
    localparam int          CFG_POL_BIT      = 14;
    localparam int          CFG_RSVD_BIT     = 13;
    localparam int          CFG_NUM_HI       = 12;
    localparam int          CFG_NUM_LO       = 8;

    // fast filter shape
    localparam int          FAST_OSR         = 64;
    localparam int          OSR_BITS         = 6;
    localparam int          SINC_W           = 19;
    localparam logic [18:0] SINC_MID         = 19'h2_0000;
    localparam logic [15:0] FILT_POS_MAX     = 16'h7FFF;

    // gain trim arithmetic
    localparam logic [17:0] GAIN_UNITY       = 18'h1_0000;
    localparam int          GAIN_SHIFT       = 16;
    localparam logic [23:0] DATA_POS_MAX     = 24'h7F_FFFF;
    localparam logic [23:0] DATA_NEG_MAX     = 24'h80_0000;

    // deglitch counter width (holds up to 128)
    localparam int          CNT_W            = 8;

    typedef struct packed {
        logic       enable;
        logic       polarity;
        logic       reserved;
        logic [4:0] count;
    } otg_cfg_t;

    typedef struct packed {
        logic        valid;
        logic [23:0] data;
    } otg_sample_t;

endpackage

/* File: logic/otg_sinc3.sv */
// third-order sinc decimator, fixed ratio, on the 1-bit modulator stream
// assumes modStrobe marks one modulator bit per pulse; clear holds it idle
`timescale 1ns/1ps
`default_nettype none
module otg_sinc3
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        clear,
    input  wire logic        modStrobe,
    input  wire logic        modBit,
    output logic             filtValid,
    output logic [15:0]      filtValue
);

    logic [18:0] int1_q, int2_q, int3_q, int1_d, int2_d, int3_d;
    logic [18:0] dly1_q, dly2_q, dly3_q, dly1_d, dly2_d, dly3_d;
    logic [5:0]  phase_q, phase_d;
    logic        valid_q, valid_d;
    logic [15:0] value_q, value_d;
    logic [18:0] c1, c2, c3;
    logic [18:0] centred;

    ////////////////////////////////////////////////////////////////////////////
    // integrators wrap on purpose: modulo arithmetic cancels in the combs
    always_comb
    begin
        int1_d  = int1_q;
        int2_d  = int2_q;
        int3_d  = int3_q;
        dly1_d  = dly1_q;
        dly2_d  = dly2_q;
        dly3_d  = dly3_q;
        phase_d = phase_q;
        valid_d = 1'b0;
        value_d = value_q;
        c1      = int3_q - dly1_q;
        c2      = c1 - dly2_q;
        c3      = c2 - dly3_q;
        centred = c3 - otg_pkg::SINC_MID;
        if (clear)
        begin
            int1_d  = '0;
            int2_d  = '0;
            int3_d  = '0;
            dly1_d  = '0;
            dly2_d  = '0;
            dly3_d  = '0;
            phase_d = '0;
        end
        else if (modStrobe)
        begin
            int1_d  = int1_q + {18'h0_0000, modBit};
            int2_d  = int2_q + int1_q;
            int3_d  = int3_q + int2_q;
            phase_d = phase_q + 6'h01;
            if (phase_q == 6'(otg_pkg::FAST_OSR - 1))
            begin
                dly1_d  = int3_q;
                dly2_d  = c1;
                dly3_d  = c2;
                valid_d = 1'b1;
                // full-scale positive lands one past the 16-bit range, so clip it
                if (!centred[18] && centred[17])
                    value_d = otg_pkg::FILT_POS_MAX;
                else
                    value_d = centred[17:2];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            int1_q  <= '0;
            int2_q  <= '0;
            int3_q  <= '0;
            dly1_q  <= '0;
            dly2_q  <= '0;
            dly3_q  <= '0;
            phase_q <= '0;
            valid_q <= 1'b0;
            value_q <= '0;
        end
        else
        begin
            int1_q  <= int1_d;
            int2_q  <= int2_d;
            int3_q  <= int3_d;
            dly1_q  <= dly1_d;
            dly2_q  <= dly2_d;
            dly3_q  <= dly3_d;
            phase_q <= phase_d;
            valid_q <= valid_d;
            value_q <= value_d;
        end
    end

    assign filtValid = valid_q;
    assign filtValue = value_q;

endmodule
`default_nettype wire

/* File: logic/otg_trip.sv */
// What this block does
// - hold channel-b gain trim as 16-bit two's complement, step 1/65536
// - multiply channel-b data by one plus signed trim
// - trip enable runs fast filter and comparator; clear stops both
// - fast filter is also held clear whenever converterEnable is low
// - trip output low on fault when polarity 0, high when 1
// - fault is the OR of high and low trip flags
// - shared pin shows fault only when its source selects trip; format shapes drive
// - flag sets only after threshold exceeded for selected consecutive conversions
// - 5-bit deglitch code decodes to a count from 1 to 128
// - fast filter is third-order sinc with fixed ratio 64
// - deglitch count restarts whenever filter output returns within threshold
// - high flag when filter above signed high limit; 7FFFh disables
// - low flag when filter below signed low limit; 8000h disables
//
// top of the trip and trim block: register port, gain trim, sinc filter, comparator, pin
// assumes a synchronous register port and a converter-enable level from the analog side
`timescale 1ns/1ps
`default_nettype none
module otg_trip
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWrData,
    output logic [15:0]      regRdData,
    input  wire logic        converterEnable,
    input  wire logic        modStrobe,
    input  wire logic        modBit,
    input  wire logic        convValid,
    input  wire logic [23:0] convData,
    output logic             calValid,
    output logic [23:0]      calData,
    input  wire logic        sharedPinSourceSelect,
    input  wire logic        sharedPinOutputFormat,
    output logic             tripHighFlag,
    output logic             tripLowFlag,
    output logic             overcurrentTripOutput,
    output logic             sharedPinOut,
    output logic             sharedPinOe
);

    // deglitch code to conversion count
    function automatic logic [7:0] decodeCount(input logic [4:0] code);
        logic [7:0] n;
        n = 8'h01;
        if (code <= 5'd9)
            n = 8'(code) + 8'h01;                       // 1..10
        else if (code <= 5'd17)
            n = 8'(code) * 8'h02 - 8'h08;               // 12..26
        else if (code == 5'd18)
            n = 8'h1C;                                  // 28
        else if (code <= 5'd23)
            n = 8'(code) * 8'h08 - 8'h78;               // 32..64
        else
            n = 8'(code) * 8'h08 - 8'h78;               // 72..128, same step of eight
        return n;
    endfunction

    // signed 16-bit greater-than, shared by both comparisons
    function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
        return $signed(a) > $signed(b);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register file
    logic [15:0]       trim_q, trim_d;
    otg_pkg::otg_cfg_t cfg_q, cfg_d;
    logic [15:0]       high_q, high_d, low_q, low_d;
    logic [15:0]       rd_q, rd_d;

    always_comb
    begin
        trim_d = trim_q;
        cfg_d  = cfg_q;
        high_d = high_q;
        low_d  = low_q;
        rd_d   = rd_q;
        if (regWrEn)
        begin
            case (regAddr)
                otg_pkg::ADDR_GAIN_TRIM: trim_d = regWrData;
                otg_pkg::ADDR_TRIP_CFG:
                begin
                    cfg_d.enable   = regWrData[otg_pkg::CFG_EN_BIT];
                    cfg_d.polarity = regWrData[otg_pkg::CFG_POL_BIT];
                    cfg_d.reserved = regWrData[otg_pkg::CFG_RSVD_BIT];
                    cfg_d.count    = regWrData[otg_pkg::CFG_NUM_HI:otg_pkg::CFG_NUM_LO];
                end
                otg_pkg::ADDR_TRIP_HIGH: high_d = regWrData;
                otg_pkg::ADDR_TRIP_LOW:  low_d  = regWrData;
                default: ;
            endcase
        end
        if (regRdEn)
        begin
            case (regAddr)
                otg_pkg::ADDR_GAIN_TRIM: rd_d = trim_q;
                otg_pkg::ADDR_TRIP_CFG:  rd_d = {cfg_q, 8'h00};
                otg_pkg::ADDR_TRIP_HIGH: rd_d = high_q;
                otg_pkg::ADDR_TRIP_LOW:  rd_d = low_q;
                default:                 rd_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            trim_q <= otg_pkg::RST_GAIN_TRIM;
            cfg_q  <= otg_pkg::RST_TRIP_CFG[15:8];
            high_q <= otg_pkg::RST_TRIP_HIGH;
            low_q  <= otg_pkg::RST_TRIP_LOW;
            rd_q   <= 16'h0000;
        end
        else
        begin
            trim_q <= trim_d;
            cfg_q  <= cfg_d;
            high_q <= high_d;
            low_q  <= low_d;
            rd_q   <= rd_d;
        end
    end

    assign regRdData = rd_q;

    ////////////////////////////////////////////////////////////////////////////
    // gain trim: data * (65536 + trim) / 65536, saturated to 24 bits
    logic signed [17:0] gainFactor;
    logic signed [41:0] gainProd;
    logic signed [25:0] gainShift;
    otg_pkg::otg_sample_t cal_q, cal_d;

    always_comb
    begin
        gainFactor = $signed(otg_pkg::GAIN_UNITY) + $signed({{2{trim_q[15]}}, trim_q});
        gainProd   = $signed(convData) * gainFactor;
        gainShift  = 26'(gainProd >>> otg_pkg::GAIN_SHIFT);
        cal_d      = cal_q;
        cal_d.valid = convValid;
        if (convValid)
        begin
            // a 1.5x gain can push full scale past 24 bits; clip rather than wrap
            if (gainShift > $signed({2'b00, otg_pkg::DATA_POS_MAX}))
                cal_d.data = otg_pkg::DATA_POS_MAX;
            else if (gainShift < $signed({2'b11, otg_pkg::DATA_NEG_MAX}))
                cal_d.data = otg_pkg::DATA_NEG_MAX;
            else
                cal_d.data = gainShift[23:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            cal_q <= '0;
        else
            cal_q <= cal_d;
    end

    assign calValid = cal_q.valid;
    assign calData  = cal_q.data;

    ////////////////////////////////////////////////////////////////////////////
    // fast filter: gated by trip enable and by converterEnable, held clear when either is low
    logic        pathOn;
    logic        filtValid;
    logic [15:0] filtValue;

    assign pathOn = cfg_q.enable && converterEnable;

    otg_sinc3 u_sinc3
    (
        .clk       (clk),
        .srst      (srst),
        .clear     (!pathOn),
        .modStrobe (modStrobe),
        .modBit    (modBit),
        .filtValid (filtValid),
        .filtValue (filtValue)
    );

    ////////////////////////////////////////////////////////////////////////////
    // comparator and deglitch counters
    logic [7:0] hiCnt_q, hiCnt_d, loCnt_q, loCnt_d;
    logic       hiFlag_q, hiFlag_d, loFlag_q, loFlag_d;
    logic [7:0] need;
    logic       aboveHigh, belowLow;

    always_comb
    begin
        need      = decodeCount(cfg_q.count);
        aboveHigh = (high_q != otg_pkg::HIGH_DISABLE) && sgt(filtValue, high_q);
        belowLow  = (low_q != otg_pkg::LOW_DISABLE) && sgt(low_q, filtValue);
        hiCnt_d   = hiCnt_q;
        loCnt_d   = loCnt_q;
        hiFlag_d  = hiFlag_q;
        loFlag_d  = loFlag_q;
        if (!pathOn)
        begin
            hiCnt_d  = '0;
            loCnt_d  = '0;
            hiFlag_d = 1'b0;
            loFlag_d = 1'b0;
        end
        else if (filtValid)
        begin
            // counters stop at the target so a long fault cannot wrap them
            if (aboveHigh)
            begin
                if (hiCnt_q < need)
                    hiCnt_d = hiCnt_q + 8'h01;
                hiFlag_d = (hiCnt_q + 8'h01) >= need;
            end
            else
            begin
                hiCnt_d  = '0;
                hiFlag_d = 1'b0;
            end
            if (belowLow)
            begin
                if (loCnt_q < need)
                    loCnt_d = loCnt_q + 8'h01;
                loFlag_d = (loCnt_q + 8'h01) >= need;
            end
            else
            begin
                loCnt_d  = '0;
                loFlag_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            hiCnt_q  <= '0;
            loCnt_q  <= '0;
            hiFlag_q <= 1'b0;
            loFlag_q <= 1'b0;
        end
        else
        begin
            hiCnt_q  <= hiCnt_d;
            loCnt_q  <= loCnt_d;
            hiFlag_q <= hiFlag_d;
            loFlag_q <= loFlag_d;
        end
    end

    assign tripHighFlag = hiFlag_q;
    assign tripLowFlag  = loFlag_q;

    ////////////////////////////////////////////////////////////////////////////
    // trip output and shared pin, one flop behind the flags
    logic trip_q, trip_d, pin_q, pin_d, oe_q, oe_d;
    logic fault;

    always_comb
    begin
        fault  = hiFlag_q || loFlag_q;
        trip_d = cfg_q.polarity ? fault : !fault;
        pin_d  = 1'b0;
        oe_d   = 1'b0;
        if (sharedPinSourceSelect)
        begin
            if (sharedPinOutputFormat)
            begin
                // open drain: only a low is driven, a high is left to the pull-up
                pin_d = 1'b0;
                oe_d  = !trip_d;
            end
            else
            begin
                pin_d = trip_d;
                oe_d  = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            trip_q <= 1'b1;
            pin_q  <= 1'b0;
            oe_q   <= 1'b0;
        end
        else
        begin
            trip_q <= trip_d;
            pin_q  <= pin_d;
            oe_q   <= oe_d;
        end
    end

    assign overcurrentTripOutput = trip_q;
    assign sharedPinOut          = pin_q;
    assign sharedPinOe           = oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_pol_fault;
        (tripHighFlag || tripLowFlag) |=> (overcurrentTripOutput == $past(cfg_q.polarity));
    endproperty
    a_pol_fault: assert property (p_pol_fault) else $error("trip level wrong on fault");

    property p_pol_idle;
        !(tripHighFlag || tripLowFlag)
            |=> (overcurrentTripOutput == !$past(cfg_q.polarity));
    endproperty
    a_pol_idle: assert property (p_pol_idle) else $error("trip level wrong when idle");

    property p_off_clears;
        !pathOn |=> !tripHighFlag && !tripLowFlag;
    endproperty
    a_off_clears: assert property (p_off_clears) else $error("flag set while path off");

    property p_high_disabled;
        (high_q == otg_pkg::HIGH_DISABLE) && $past(high_q == otg_pkg::HIGH_DISABLE)
            && $past(!tripHighFlag) |-> !tripHighFlag;
    endproperty
    a_high_disabled: assert property (p_high_disabled) else $error("high flag with limit off");

    property p_low_disabled;
        (low_q == otg_pkg::LOW_DISABLE) && $past(low_q == otg_pkg::LOW_DISABLE)
            && $past(!tripLowFlag) |-> !tripLowFlag;
    endproperty
    a_low_disabled: assert property (p_low_disabled) else $error("low flag with limit off");

    property p_rise_needs_count;
        $rose(tripHighFlag) |-> ($past(hiCnt_q) + 8'h01 >= $past(need));
    endproperty
    a_rise_needs_count: assert property (p_rise_needs_count) else $error("high flag too early");

    property p_restart;
        pathOn && filtValid && !aboveHigh |=> (hiCnt_q == 8'h00) && !tripHighFlag;
    endproperty
    a_restart: assert property (p_restart) else $error("deglitch count not restarted");

    property p_pin_released;
        !sharedPinSourceSelect |=> !sharedPinOe;
    endproperty
    a_pin_released: assert property (p_pin_released) else $error("pin driven when not chosen");

    property p_cfg_low_byte;
        regRdEn && (regAddr == otg_pkg::ADDR_TRIP_CFG) |=> (regRdData[7:0] == 8'h00);
    endproperty
    a_cfg_low_byte: assert property (p_cfg_low_byte) else $error("config low byte not zero");

    property p_unity_gain;
        convValid && (trim_q == 16'h0000) |=> calValid && (calData == $past(convData));
    endproperty
    a_unity_gain: assert property (p_unity_gain) else $error("zero trim not unity");

endmodule
`default_nettype wire

/* File: sim/otg_mod_src.sv */
// modulator bit source standing in for the channel-b converter
// assumes one strobe per clock while run is high; inputs change after the edge
`timescale 1ns/1ps
`default_nettype none
module otg_mod_src
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic run,
    input  wire logic level,
    output logic      modStrobe,
    output logic      modBit
);
    // idle bit toggles so a stale bit never passes for a live one
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            modStrobe <= 1'b0;
            modBit    <= 1'b0;
        end
        else
        begin
            modStrobe <= run;
            modBit    <= run ? level : ~modBit;
        end
    end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the trip and trim block
// assumes otg_pkg, otg_sinc3, otg_trip and otg_mod_src compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic        gain;
        logic [7:0]  addr;
        logic [15:0] wr;
        logic [23:0] data;
        logic [23:0] exp;
    } otg_tb_row_t;
    typedef struct packed {
        logic [4:0] code;
        logic [7:0] n;
        logic       pol;
        logic       fmt;
        logic       sel;
        logic       trip;
        logic       out;
        logic       oe;
    } otg_tb_trip_t;
    // register rows then gain rows: inputs beside expected result
    localparam otg_tb_row_t ROWS [12] = '{
        '{1'b0, 8'hC6, 16'h8001, 24'h00_0000, 24'h00_8001},
        '{1'b0, 8'hC7, 16'h85FF, 24'h00_0000, 24'h00_8500},
        '{1'b0, 8'hC8, 16'h8000, 24'h00_0000, 24'h00_8000},
        '{1'b0, 8'hC9, 16'h7FFF, 24'h00_0000, 24'h00_7FFF},
        '{1'b0, 8'hCA, 16'hFFFF, 24'h00_0000, 24'h00_0000},
        '{1'b1, 8'hC6, 16'h0000, 24'h10_0000, 24'h10_0000},
        '{1'b1, 8'hC6, 16'h7FFF, 24'h01_0000, 24'h01_7FFF},
        '{1'b1, 8'hC6, 16'h8000, 24'h01_0000, 24'h00_8000},
        '{1'b1, 8'hC6, 16'h7FFF, 24'h7F_FFFF, 24'h7F_FFFF},
        '{1'b1, 8'hC6, 16'h7FFF, 24'h80_0000, 24'h80_0000},
        '{1'b1, 8'hC6, 16'h8000, 24'hFF_FFFF, 24'hFF_FFFF},
        '{1'b1, 8'hC6, 16'hFFFF, 24'h80_0000, 24'h80_0080}
    };
    // deglitch code, count, polarity and pin setup with expected pin state
    localparam otg_tb_trip_t TRIPS [6] = '{
        '{5'h00, 8'h01, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1},
        '{5'h09, 8'h0A, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1},
        '{5'h0A, 8'h0C, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
        '{5'h12, 8'h1C, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1},
        '{5'h13, 8'h20, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
        '{5'h1F, 8'h80, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0}
    };
    logic        clk, srst, regWrEn, regRdEn, converterEnable;
    logic        modStrobe, modBit, convValid, calValid, srcRun, srcLevel;
    logic        sharedPinSourceSelect, sharedPinOutputFormat;
    logic        tripHighFlag, tripLowFlag, overcurrentTripOutput;
    logic        sharedPinOut, sharedPinOe;
    logic [7:0]  regAddr;
    logic [15:0] regWrData, regRdData;
    logic [23:0] convData, calData;
    int          errorCnt, checks;
    ////////////////////////////////////////////////////////////////
    otg_trip dut_u (.clk(clk), .srst(srst), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .converterEnable(converterEnable), .modStrobe(modStrobe), .modBit(modBit),
        .convValid(convValid), .convData(convData), .calValid(calValid),
        .calData(calData), .sharedPinSourceSelect(sharedPinSourceSelect),
        .sharedPinOutputFormat(sharedPinOutputFormat), .tripHighFlag(tripHighFlag),
        .tripLowFlag(tripLowFlag), .overcurrentTripOutput(overcurrentTripOutput),
        .sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe));
    otg_mod_src src_u (.clk(clk), .srst(srst), .run(srcRun), .level(srcLevel),
        .modStrobe(modStrobe), .modBit(modBit));
    ////////////////////////////////////////////////////////////////
    task automatic chkW(input logic [23:0] g, input logic [23:0] e);
        checks++;
        if (g !== e)
        begin
            errorCnt++;
            $display("[ERR] %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chkB(input logic g, input logic e);
        checks++;
        if (g !== e)
        begin
            errorCnt++;
            $display("[ERR] %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrEn   <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn   <= 1'b0;
    endtask
    // answer lands on the same edge that takes the strobe
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        chkW({8'h00, regRdData}, {8'h00, e});
    endtask
    task automatic cfg(input logic en, input logic pol, input logic [4:0] code);
        wr(8'hC7, {en, pol, 1'b0, code, 8'h00});
    endtask
    // bounded wait, the caller compares the flag afterwards
    task automatic waitFlag(input logic lo, input int lim);
        for (int i = 0; i < lim; i++)
        begin
            @(posedge clk);
            #1;
            if ((lo ? tripLowFlag : tripHighFlag) === 1'b1)
                break;
        end
    endtask
    task automatic conclude;
        if (errorCnt == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // free-running 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // watchdog well beyond the expected 20k cycles
    initial
    begin
        #(40 * 60000);
        errorCnt++;
        conclude();
    end
    // main sequence
    initial
    begin
        srst = 1'b1;
        {regWrEn, regRdEn, convValid, srcRun, srcLevel} = 5'h00;
        {converterEnable, sharedPinSourceSelect, sharedPinOutputFormat} = 3'h0;
        {regAddr, regWrData, convData} = 48'h0000_0000_0000;
        errorCnt = 0;
        checks = 0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        for (int i = 0; i < 12; i++)
        begin
            if (ROWS[i].gain)
            begin
                wr(8'hC6, ROWS[i].wr);
                @(posedge clk);
                convValid <= 1'b1;
                convData  <= ROWS[i].data;
                @(posedge clk);
                convValid <= 1'b0;
                #1;
                chkB(calValid, 1'b1);
                chkW(calData, ROWS[i].exp);
            end
            else
            begin
                wr(ROWS[i].addr, ROWS[i].wr);
                rd(ROWS[i].addr, ROWS[i].exp[15:0]);
            end
        end
        // second reset in mid-run restores the register defaults
        @(posedge clk);
        srst <= 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        #1;
        chkB(overcurrentTripOutput, 1'b1);
        chkB(sharedPinOe, 1'b0);
        rd(8'hC6, 16'h0000);
        rd(8'hC7, 16'h0000);
        rd(8'hC8, 16'h7FFF);
        rd(8'hC9, 16'h8000);
        wr(8'hC8, 16'h0000);
        converterEnable <= 1'b1;
        srcLevel        <= 1'b1;
        // flag may not rise before the selected count of filter outputs
        for (int i = 0; i < 6; i++)
        begin
            cfg(1'b1, TRIPS[i].pol, TRIPS[i].code);
            srcRun                <= 1'b1;
            sharedPinOutputFormat <= TRIPS[i].fmt;
            sharedPinSourceSelect <= TRIPS[i].sel;
            repeat (64 * TRIPS[i].n) @(posedge clk);
            #1;
            chkB(tripHighFlag, 1'b0);
            waitFlag(1'b0, 320);
            chkB(tripHighFlag, 1'b1);
            repeat (2) @(posedge clk);
            #1;
            chkB(overcurrentTripOutput, TRIPS[i].trip);
            chkB(sharedPinOe, TRIPS[i].oe);
            if (TRIPS[i].sel)
                chkB(sharedPinOut, TRIPS[i].out);
            cfg(1'b0, 1'b0, 5'h00);
            srcRun <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            chkB(tripHighFlag, 1'b0);
        end
        // full-scale limits switch detection off, then a real low limit
        wr(8'hC8, 16'h7FFF);
        cfg(1'b1, 1'b0, 5'h00);
        srcRun <= 1'b1;
        repeat (384) @(posedge clk);
        #1;
        chkB(tripHighFlag, 1'b0);
        @(posedge clk);
        srcLevel <= 1'b0;
        repeat (384) @(posedge clk);
        #1;
        chkB(tripLowFlag, 1'b0);
        wr(8'hC9, 16'hF000);
        waitFlag(1'b1, 320);
        chkB(tripLowFlag, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        chkB(overcurrentTripOutput, 1'b0);
        // a dip inside the limit restarts the count of ten
        wr(8'hC9, 16'h8000);
        wr(8'hC8, 16'h0000);
        cfg(1'b1, 1'b0, 5'h09);
        srcLevel <= 1'b1;
        repeat (384) @(posedge clk);
        srcLevel <= 1'b0;
        repeat (256) @(posedge clk);
        srcLevel <= 1'b1;
        repeat (576) @(posedge clk);
        #1;
        chkB(tripHighFlag, 1'b0);
        waitFlag(1'b0, 320);
        chkB(tripHighFlag, 1'b1);
        // converter off holds the whole path idle
        @(posedge clk);
        converterEnable <= 1'b0;
        repeat (384) @(posedge clk);
        #1;
        chkB(tripHighFlag, 1'b0);
        @(posedge clk);
        converterEnable <= 1'b1;
        waitFlag(1'b0, 896);
        chkB(tripHighFlag, 1'b1);
        conclude();
    end
endmodule
`default_nettype wire
